// *** shared/ete_consts.vh ***
// Constants of the event transfer engine: record layout, fields, codes
`ifndef ETE_CONSTS_VH
`define ETE_CONSTS_VH
// Record word byte offsets from the record base
`define ETE_REC_MODE 32'h0000_0000
`define ETE_REC_SAR 32'h0000_0004
`define ETE_REC_DAR 32'h0000_0008
`define ETE_REC_CNT 32'h0000_000C
`define ETE_REC_STRIDE 32'h0000_0010
// Mode word field positions
`define ETE_MD_HI 31
`define ETE_MD_LO 30
`define ETE_SZ_HI 29
`define ETE_SZ_LO 28
`define ETE_SM_HI 27
`define ETE_SM_LO 26
`define ETE_DM_HI 25
`define ETE_DM_LO 24
`define ETE_CHAIN_BIT 23
`define ETE_EVERY_BIT 22
`define ETE_RPT_DST_BIT 21
// Operating modes
`define ETE_MODE_NORMAL 2'h0
`define ETE_MODE_REPEAT 2'h1
`define ETE_MODE_BLOCK 2'h2
// Data unit sizes
`define ETE_SIZE_8 2'h0
`define ETE_SIZE_16 2'h1
`define ETE_SIZE_32 2'h2
// Address modes
`define ETE_AM_INC 2'h2
`define ETE_AM_DEC 2'h3
// Reset values
`define ETE_RST_WORD 32'h0000_0000
`define ETE_RST_CNT 16'h0000
`endif

// *** hdl/pair_buffer.v ***
// Two-entry data buffer with valid and ready on both sides
`timescale 1ns/10ps
module pair_buffer #(
  parameter W = 32
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] slot0_ff;
  reg [W-1:0] slot1_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_data = slot0_ff;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_ff <= 2'h0;
      slot0_ff <= {W{1'b0}};
      slot1_ff <= {W{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_ff == 2'h0) begin
            slot0_ff <= i_in_data;
          end else begin
            slot1_ff <= i_in_data;
          end
          cnt_ff <= cnt_ff + 2'h1;
        end
        2'b01: begin
          slot0_ff <= slot1_ff;
          cnt_ff <= cnt_ff - 2'h1;
        end
        2'b11: begin
          // Full buffer refuses a push, so only one word can be held here
          slot0_ff <= i_in_data;
        end
        default: begin
          cnt_ff <= cnt_ff;
        end
      endcase
    end
  end
endmodule // pair_buffer

// *** hdl/event_transfer_engine.v ***
// Event transfer engine: vectored record fetch, unit moves, write-back
//
// Behaviour
// - Record fetched from RAM through source vector
// - Normal, repeat, block modes chosen per record
// - Start only for activation-enabled sources
// - Moves between any memory or peripheral addresses
// - Data unit is 8, 16 or 32 bits
// - Block length one to 256 units
// - Normal count one to 65536 transfers
// - Repeat count one to 256, then restarts
// - Block count one to 65536 blocks
// - Source interrupt request triggers activation
// - Optional CPU interrupt after every transfer
// - Optional CPU interrupt when count exhausted
// - Separate record per source via its vector
// - Optional skip of record re-read
// - Chain bit continues with next record
// - Interrupt select: every transfer or at end
`timescale 1ns/10ps
`include "ete_consts.vh"
module event_transfer_engine #(
  parameter N_SRC = 8,
  parameter SRC_W = 3
) (
  input wire I_SYS_CLK,
  input wire I_SYS_RST,
  input wire [N_SRC-1:0] I_IRQ_REQ,
  input wire [N_SRC-1:0] I_ACT_EN,
  input wire [31:0] I_VEC_BASE,
  input wire I_READ_SKIP_EN,
  input wire I_MEM_ACK,
  input wire [31:0] I_MEM_RDATA,
  output reg O_MEM_REQ,
  output reg O_MEM_WE,
  output reg [31:0] O_MEM_ADDR,
  output reg [31:0] O_MEM_WDATA,
  output reg [1:0] O_MEM_SIZE,
  output reg [N_SRC-1:0] O_SRC_ACCEPT,
  output reg [N_SRC-1:0] O_CPU_IRQ,
  output reg O_BUSY
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_VEC = 3'h1;
  localparam [2:0] ST_FETCH = 3'h2;
  localparam [2:0] ST_RD = 3'h3;
  localparam [2:0] ST_WR = 3'h4;
  localparam [2:0] ST_WB = 3'h5;
  localparam [2:0] ST_DONE = 3'h6;

  function [31:0] unit_bytes;
    input [1:0] sz;
    begin
      unit_bytes = 32'h0000_0001 << sz;
    end
  endfunction

  function [31:0] addr_step;
    input [31:0] a;
    input [1:0] am;
    input [1:0] sz;
    begin
      if (am == `ETE_AM_INC) begin
        addr_step = a + unit_bytes(sz);
      end else if (am == `ETE_AM_DEC) begin
        addr_step = a - unit_bytes(sz);
      end else begin
        addr_step = a;
      end
    end
  endfunction

  // Undo a whole repeat area; a reload of zero stands for 256 units
  function [31:0] addr_restore;
    input [31:0] a;
    input [1:0] am;
    input [1:0] sz;
    input [7:0] rl;
    reg [31:0] amt;
    begin
      amt = (rl == 8'h00) ? 32'h0000_0100 : {24'h00_0000, rl};
      amt = amt << sz;
      if (am == `ETE_AM_INC) begin
        addr_restore = a - amt;
      end else if (am == `ETE_AM_DEC) begin
        addr_restore = a + amt;
      end else begin
        addr_restore = a;
      end
    end
  endfunction

  reg [2:0] state_ff;
  reg [1:0] idx_ff;
  reg [SRC_W-1:0] src_ff;
  reg [SRC_W-1:0] last_src_ff;
  reg cache_ok_ff;
  reg irq_pend_ff;
  reg [31:0] rec_ff;
  reg [31:0] mode_ff;
  reg [31:0] sar_ff;
  reg [31:0] dar_ff;
  reg [15:0] cra_ff;
  reg [15:0] crb_ff;
  reg [2:0] nxt_state;
  reg [1:0] nxt_idx;
  reg [SRC_W-1:0] nxt_src;
  reg [SRC_W-1:0] nxt_last_src;
  reg nxt_cache_ok;
  reg nxt_irq_pend;
  reg [31:0] nxt_rec;
  reg [31:0] nxt_mode;
  reg [31:0] nxt_sar;
  reg [31:0] nxt_dar;
  reg [15:0] nxt_cra;
  reg [15:0] nxt_crb;
  reg nxt_req;
  reg nxt_we;
  reg [31:0] nxt_addr;
  reg [31:0] nxt_wdata;
  reg [1:0] nxt_size;
  reg [N_SRC-1:0] nxt_accept;
  reg [N_SRC-1:0] nxt_irq;
  reg nxt_busy;
  reg [SRC_W-1:0] pick;
  integer k;

  wire [N_SRC-1:0] pend = I_IRQ_REQ & I_ACT_EN;
  wire bus_done = O_MEM_REQ & I_MEM_ACK;
  wire [1:0] md = mode_ff[`ETE_MD_HI:`ETE_MD_LO];
  wire [1:0] sz = mode_ff[`ETE_SZ_HI:`ETE_SZ_LO];
  wire [1:0] sm = mode_ff[`ETE_SM_HI:`ETE_SM_LO];
  wire [1:0] dm = mode_ff[`ETE_DM_HI:`ETE_DM_LO];
  wire rpt_dst = mode_ff[`ETE_RPT_DST_BIT];
  wire unit_last = (cra_ff[7:0] == 8'h01);
  wire [31:0] dar_adv = addr_step(dar_ff, dm, sz);
  wire [31:0] rec_word = rec_ff + {28'h000_0000, idx_ff, 2'b00};
  wire [31:0] wb_addr = rec_word + `ETE_REC_SAR;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [31:0] buf_out_data;
  wire buf_push = (state_ff == ST_RD) & bus_done;
  wire buf_pop = (state_ff == ST_WR) & bus_done;

  // Lowest numbered pending source wins
  always @* begin
    pick = {SRC_W{1'b0}};
    for (k = N_SRC - 1; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        pick = k[SRC_W-1:0];
      end
    end
  end

  // Read data waits here so a stalled write side loses no word
  pair_buffer #(
    .W(32)
  ) u_buf (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_in_valid(buf_push),
    .o_in_ready(buf_in_ready),
    .i_in_data(I_MEM_RDATA),
    .o_out_valid(buf_out_valid),
    .i_out_ready(buf_pop),
    .o_out_data(buf_out_data)
  );

  always @* begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_src = src_ff;
    nxt_last_src = last_src_ff;
    nxt_cache_ok = cache_ok_ff;
    nxt_irq_pend = irq_pend_ff;
    nxt_rec = rec_ff;
    nxt_mode = mode_ff;
    nxt_sar = sar_ff;
    nxt_dar = dar_ff;
    nxt_cra = cra_ff;
    nxt_crb = crb_ff;
    nxt_req = O_MEM_REQ & ~I_MEM_ACK;
    nxt_we = O_MEM_WE;
    nxt_addr = O_MEM_ADDR;
    nxt_wdata = O_MEM_WDATA;
    nxt_size = O_MEM_SIZE;
    nxt_accept = {N_SRC{1'b0}};
    nxt_irq = {N_SRC{1'b0}};
    nxt_busy = (state_ff != ST_IDLE);
    case (state_ff)
      ST_IDLE: begin
        if (|pend) begin
          nxt_src = pick;
          nxt_accept[pick] = 1'b1;
          nxt_irq_pend = 1'b0;
          nxt_busy = 1'b1;
          // Held record is only valid if software left RAM untouched
          if (I_READ_SKIP_EN && cache_ok_ff && last_src_ff == pick) begin
            nxt_state = ST_RD;
          end else begin
            nxt_state = ST_VEC;
          end
        end
      end
      ST_VEC: begin
        if (!O_MEM_REQ) begin
          nxt_req = 1'b1;
          nxt_we = 1'b0;
          nxt_size = `ETE_SIZE_32;
          nxt_addr = I_VEC_BASE + {{(30 - SRC_W){1'b0}}, src_ff, 2'b00};
        end else if (I_MEM_ACK) begin
          nxt_rec = I_MEM_RDATA;
          nxt_idx = 2'h0;
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!O_MEM_REQ) begin
          nxt_req = 1'b1;
          nxt_we = 1'b0;
          nxt_size = `ETE_SIZE_32;
          nxt_addr = rec_word;
        end else if (I_MEM_ACK) begin
          nxt_idx = idx_ff + 2'h1;
          case (idx_ff)
            2'h0: nxt_mode = I_MEM_RDATA;
            2'h1: nxt_sar = I_MEM_RDATA;
            2'h2: nxt_dar = I_MEM_RDATA;
            default: begin
              nxt_cra = I_MEM_RDATA[31:16];
              nxt_crb = I_MEM_RDATA[15:0];
              nxt_state = ST_RD;
            end
          endcase
        end
      end
      ST_RD: begin
        if (!O_MEM_REQ && buf_in_ready) begin
          nxt_req = 1'b1;
          nxt_we = 1'b0;
          nxt_size = sz;
          nxt_addr = sar_ff;
        end else if (bus_done) begin
          nxt_sar = addr_step(sar_ff, sm, sz);
          nxt_state = ST_WR;
        end
      end
      ST_WR: begin
        if (!O_MEM_REQ && buf_out_valid) begin
          nxt_req = 1'b1;
          nxt_we = 1'b1;
          nxt_size = sz;
          nxt_addr = dar_ff;
          nxt_wdata = buf_out_data;
        end else if (bus_done) begin
          nxt_dar = dar_adv;
          nxt_state = ST_WB;
          if (mode_ff[`ETE_EVERY_BIT]) begin
            nxt_irq_pend = 1'b1;
          end
          case (md)
            `ETE_MODE_REPEAT: begin
              if (unit_last) begin
                nxt_cra = {cra_ff[15:8], cra_ff[15:8]};
                if (rpt_dst) begin
                  nxt_dar = addr_restore(dar_adv, dm, sz, cra_ff[15:8]);
                end else begin
                  nxt_sar = addr_restore(sar_ff, sm, sz, cra_ff[15:8]);
                end
              end else begin
                nxt_cra = {cra_ff[15:8], cra_ff[7:0] - 8'h01};
              end
            end
            `ETE_MODE_BLOCK: begin
              if (unit_last) begin
                nxt_cra = {cra_ff[15:8], cra_ff[15:8]};
                nxt_crb = crb_ff - 16'h0001;
                if (rpt_dst) begin
                  nxt_dar = addr_restore(dar_adv, dm, sz, cra_ff[15:8]);
                end else begin
                  nxt_sar = addr_restore(sar_ff, sm, sz, cra_ff[15:8]);
                end
                if (crb_ff == 16'h0001 && !mode_ff[`ETE_EVERY_BIT]) begin
                  nxt_irq_pend = 1'b1;
                end
              end else begin
                nxt_cra = {cra_ff[15:8], cra_ff[7:0] - 8'h01};
                nxt_state = ST_RD;
              end
            end
            default: begin
              // Count of zero wraps, giving the full 65536 transfers
              nxt_cra = cra_ff - 16'h0001;
              if (cra_ff == 16'h0001 && !mode_ff[`ETE_EVERY_BIT]) begin
                nxt_irq_pend = 1'b1;
              end
            end
          endcase
          nxt_idx = 2'h0;
        end
      end
      ST_WB: begin
        if (!O_MEM_REQ) begin
          // Words that cannot have changed are not written back
          if ((idx_ff == 2'h0 && sm != `ETE_AM_INC && sm != `ETE_AM_DEC) ||
              (idx_ff == 2'h1 && dm != `ETE_AM_INC && dm != `ETE_AM_DEC)) begin
            nxt_idx = idx_ff + 2'h1;
          end else begin
            nxt_req = 1'b1;
            nxt_we = 1'b1;
            nxt_size = `ETE_SIZE_32;
            nxt_addr = wb_addr;
            if (idx_ff == 2'h0) begin
              nxt_wdata = sar_ff;
            end else if (idx_ff == 2'h1) begin
              nxt_wdata = dar_ff;
            end else begin
              nxt_wdata = {cra_ff, crb_ff};
            end
          end
        end else if (I_MEM_ACK) begin
          nxt_idx = idx_ff + 2'h1;
          if (idx_ff == 2'h2) begin
            nxt_idx = 2'h0;
            if (mode_ff[`ETE_CHAIN_BIT]) begin
              nxt_rec = rec_ff + `ETE_REC_STRIDE;
              nxt_cache_ok = 1'b0;
              nxt_state = ST_FETCH;
            end else begin
              nxt_cache_ok = 1'b1;
              nxt_last_src = src_ff;
              nxt_state = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        if (irq_pend_ff) begin
          nxt_irq[src_ff] = 1'b1;
        end
        nxt_busy = 1'b0;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      state_ff <= ST_IDLE;
      idx_ff <= 2'h0;
      src_ff <= {SRC_W{1'b0}};
      last_src_ff <= {SRC_W{1'b0}};
      cache_ok_ff <= 1'b0;
      irq_pend_ff <= 1'b0;
      rec_ff <= `ETE_RST_WORD;
      mode_ff <= `ETE_RST_WORD;
      sar_ff <= `ETE_RST_WORD;
      dar_ff <= `ETE_RST_WORD;
      cra_ff <= `ETE_RST_CNT;
      crb_ff <= `ETE_RST_CNT;
      O_MEM_REQ <= 1'b0;
      O_MEM_WE <= 1'b0;
      O_MEM_ADDR <= `ETE_RST_WORD;
      O_MEM_WDATA <= `ETE_RST_WORD;
      O_MEM_SIZE <= `ETE_SIZE_8;
      O_SRC_ACCEPT <= {N_SRC{1'b0}};
      O_CPU_IRQ <= {N_SRC{1'b0}};
      O_BUSY <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      src_ff <= nxt_src;
      last_src_ff <= nxt_last_src;
      cache_ok_ff <= nxt_cache_ok;
      irq_pend_ff <= nxt_irq_pend;
      rec_ff <= nxt_rec;
      mode_ff <= nxt_mode;
      sar_ff <= nxt_sar;
      dar_ff <= nxt_dar;
      cra_ff <= nxt_cra;
      crb_ff <= nxt_crb;
      O_MEM_REQ <= nxt_req;
      O_MEM_WE <= nxt_we;
      O_MEM_ADDR <= nxt_addr;
      O_MEM_WDATA <= nxt_wdata;
      O_MEM_SIZE <= nxt_size;
      O_SRC_ACCEPT <= nxt_accept;
      O_CPU_IRQ <= nxt_irq;
      O_BUSY <= nxt_busy;
    end
  end
endmodule // event_transfer_engine

// *** tb/event_transfer_engine_monitor.sv ***
// Port checker of the event transfer engine
`timescale 1ns/10ps
module event_transfer_engine_monitor #(
  parameter N_SRC = 8,
  parameter SRC_W = 3
) (
  input wire I_SYS_CLK,
  input wire I_SYS_RST,
  input wire [N_SRC-1:0] I_IRQ_REQ,
  input wire [N_SRC-1:0] I_ACT_EN,
  input wire I_MEM_ACK,
  input wire O_MEM_REQ,
  input wire O_MEM_WE,
  input wire [31:0] O_MEM_ADDR,
  input wire [31:0] O_MEM_WDATA,
  input wire [1:0] O_MEM_SIZE,
  input wire [N_SRC-1:0] O_SRC_ACCEPT,
  input wire [N_SRC-1:0] O_CPU_IRQ,
  input wire O_BUSY
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  req_hold_a: assert property (
    O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_ADDR)
    && $stable(O_MEM_WE) && $stable(O_MEM_WDATA))
    else $error("Bus request changed before acknowledge");
  ack_drop_a: assert property (
    O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ)
    else $error("Bus request kept after acknowledge");
  accept_enabled_a: assert property (
    |O_SRC_ACCEPT |-> (O_SRC_ACCEPT & ~$past(I_ACT_EN)) == '0)
    else $error("Disabled source accepted");
  accept_requested_a: assert property (
    |O_SRC_ACCEPT |-> (O_SRC_ACCEPT & ~$past(I_IRQ_REQ)) == '0)
    else $error("Source accepted without request");
  accept_single_a: assert property (
    $onehot0(O_SRC_ACCEPT))
    else $error("Several sources accepted at once");
  accept_pulse_a: assert property (
    |O_SRC_ACCEPT |=> O_SRC_ACCEPT == '0 && O_BUSY)
    else $error("Accept not a single pulse into busy");
  vector_read_a: assert property (
    |O_SRC_ACCEPT |-> ##[0:3] (O_MEM_REQ && !O_MEM_WE))
    else $error("No vector read after accept");
  busy_accept_a: assert property (
    O_BUSY && $past(O_BUSY) |-> O_SRC_ACCEPT == '0)
    else $error("Accept while an activation runs");
  irq_pulse_a: assert property (
    |O_CPU_IRQ |=> O_CPU_IRQ == '0)
    else $error("CPU interrupt longer than one cycle");
  size_legal_a: assert property (
    O_MEM_REQ |-> O_MEM_SIZE != 2'h3)
    else $error("Illegal data unit size");
  cover property (|O_SRC_ACCEPT);
  cover property (|O_CPU_IRQ);
  cover property (O_MEM_REQ && O_MEM_WE && I_MEM_ACK);
endmodule // event_transfer_engine_monitor

bind event_transfer_engine event_transfer_engine_monitor #(
  .N_SRC(N_SRC), .SRC_W(SRC_W)) mon (.I_SYS_CLK(I_SYS_CLK),
  .I_SYS_RST(I_SYS_RST), .I_IRQ_REQ(I_IRQ_REQ), .I_ACT_EN(I_ACT_EN),
  .I_MEM_ACK(I_MEM_ACK), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE),
  .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA),
  .O_MEM_SIZE(O_MEM_SIZE), .O_SRC_ACCEPT(O_SRC_ACCEPT),
  .O_CPU_IRQ(O_CPU_IRQ), .O_BUSY(O_BUSY));

// *** tb/mem_partner.sv ***
// Memory partner answering the engine's bus requests
`timescale 1ns/10ps
module mem_partner (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] i_size,
  input wire logic i_slow,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:255];
  logic [2:0] wsz_seen;
  int n_rd;
  int wait_cnt;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0000_0000;
    wsz_seen = 3'h0;
    n_rd = 0;
    wait_cnt = 0;
  end
  always @(posedge i_clk) begin
    // Idle data bus toggles so a stale word is never mistaken for data
    o_rdata <= ~o_rdata;
    o_ack <= 1'b0;
    if (!i_req || o_ack) begin
      wait_cnt <= 0;
    end else if (wait_cnt < (i_slow ? 3 : 0)) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      o_ack <= 1'b1;
      if (i_we) begin
        wsz_seen[i_size] <= 1'b1;
        case (i_size)
          2'h0: mem[i_addr[9:2]][8*i_addr[1:0] +: 8] <= i_wdata[7:0];
          2'h1: mem[i_addr[9:2]][16*i_addr[1] +: 16] <= i_wdata[15:0];
          default: mem[i_addr[9:2]] <= i_wdata;
        endcase
      end else begin
        // Sub-word units come back in the low bits, as writes take them
        case (i_size)
          2'h0: o_rdata <= mem[i_addr[9:2]] >> (8 * i_addr[1:0]);
          2'h1: o_rdata <= mem[i_addr[9:2]] >> (16 * i_addr[1]);
          default: o_rdata <= mem[i_addr[9:2]];
        endcase
        n_rd <= n_rd + 1;
      end
    end
  end
endmodule // mem_partner

// *** tb/event_transfer_engine_tb_top.sv ***
// Testbench of the event transfer engine
`timescale 1ns/10ps
module event_transfer_engine_tb_top;
  logic clk, rst, skip, slow, mreq, mwe, mack, busy;
  logic [7:0] req, en, acc, irq, acc_seen, irq_seen;
  logic [31:0] addr, wdata, rdata;
  logic [1:0] msize;
  int n_errors, n_tests, cyc, rd_act, rd0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  event_transfer_engine #(.N_SRC(8), .SRC_W(3)) dut (.I_SYS_CLK(clk),
    .I_SYS_RST(rst), .I_IRQ_REQ(req), .I_ACT_EN(en),
    .I_VEC_BASE(32'h0000_0000), .I_READ_SKIP_EN(skip), .I_MEM_ACK(mack),
    .I_MEM_RDATA(rdata), .O_MEM_REQ(mreq), .O_MEM_WE(mwe),
    .O_MEM_ADDR(addr), .O_MEM_WDATA(wdata), .O_MEM_SIZE(msize),
    .O_SRC_ACCEPT(acc), .O_CPU_IRQ(irq), .O_BUSY(busy));
  mem_partner mem (.i_clk(clk), .i_req(mreq), .i_we(mwe), .i_addr(addr),
    .i_wdata(wdata), .i_size(msize), .i_slow(slow), .o_ack(mack),
    .o_rdata(rdata));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    acc_seen <= acc_seen | acc;
    irq_seen <= irq_seen | irq;
    // Ceiling well above the few hundred cycles the tests need
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task put(input logic [31:0] a, d);
    mem.mem[a[9:2]] = d;
  endtask
  function logic [31:0] peek(input logic [31:0] a);
    return mem.mem[a[9:2]];
  endfunction
  task activate(input int s);
    int k, r0;
    @(posedge clk);
    #1;
    acc_seen = 8'h00;
    irq_seen = 8'h00;
    r0 = mem.n_rd;
    req[s] = 1'b1;
    k = 0;
    while (acc[s] !== 1'b1 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    req[s] = 1'b0;
    check("accept", 32'(acc[s]), 32'h0000_0001);
    @(posedge clk);
    #1;
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (3) @(posedge clk);
    #1;
    rd_act = mem.n_rd - r0;
  endtask
  task t_normal;
    put(32'h0000_0000, 32'h0000_0040);
    put(32'h0000_0040, 32'h2A00_0000);
    put(32'h0000_0044, 32'h0000_0100);
    put(32'h0000_0048, 32'h0000_0200);
    put(32'h0000_004C, 32'h0002_0000);
    put(32'h0000_0100, 32'hA5A5_1234);
    put(32'h0000_0104, 32'h5A5A_9876);
    activate(0);
    check("dst0", peek(32'h0000_0200), 32'hA5A5_1234);
    check("sar", peek(32'h0000_0044), 32'h0000_0104);
    check("dar", peek(32'h0000_0048), 32'h0000_0204);
    check("cnt", peek(32'h0000_004C), 32'h0001_0000);
    check("irq mid", 32'(irq_seen), 32'h0000_0000);
    skip = 1'b1;
    rd0 = rd_act;
    activate(0);
    skip = 1'b0;
    check("dst1", peek(32'h0000_0204), 32'h5A5A_9876);
    check("reads", 32'(rd_act), 32'h0000_0001);
    check("reads full", 32'(rd0), 32'h0000_0006);
    check("irq end", 32'(irq_seen), 32'h0000_0001);
    check("cnt end", peek(32'h0000_004C), 32'h0000_0000);
  endtask
  task t_repeat;
    put(32'h0000_0004, 32'h0000_0060);
    put(32'h0000_0060, 32'h4800_0000);
    put(32'h0000_0064, 32'h0000_0110);
    put(32'h0000_0068, 32'h0000_0210);
    put(32'h0000_006C, 32'h0202_0000);
    put(32'h0000_0110, 32'h0000_0011);
    put(32'h0000_0210, 32'hFFFF_FFFF);
    en[1] = 1'b0;
    acc_seen = 8'h00;
    req[1] = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check("gated", 32'(acc_seen), 32'h0000_0000);
    req[1] = 1'b0;
    en[1] = 1'b1;
    activate(1);
    check("rpt sar", peek(32'h0000_0064), 32'h0000_0111);
    check("rpt cnt", peek(32'h0000_006C), 32'h0201_0000);
    check("rpt dst", peek(32'h0000_0210), 32'hFFFF_FF11);
    activate(1);
    check("rpt sar2", peek(32'h0000_0064), 32'h0000_0110);
    check("rpt cnt2", peek(32'h0000_006C), 32'h0202_0000);
    check("rpt dst2", peek(32'h0000_0210), 32'hFFFF_FF00);
    check("rpt dar", peek(32'h0000_0068), 32'h0000_0210);
    check("rpt irq", 32'(irq_seen), 32'h0000_0000);
  endtask
  task t_block_chain;
    // Slow memory stalls every access for three extra cycles
    slow = 1'b1;
    put(32'h0000_0008, 32'h0000_0080);
    put(32'h0000_0080, 32'hAAE0_0000);
    put(32'h0000_0084, 32'h0000_0120);
    put(32'h0000_0088, 32'h0000_0220);
    put(32'h0000_008C, 32'h0202_0001);
    // Chained record counts its destination down
    put(32'h0000_0090, 32'h1B00_0000);
    put(32'h0000_0094, 32'h0000_0130);
    put(32'h0000_0098, 32'h0000_0230);
    put(32'h0000_009C, 32'h0001_0000);
    put(32'h0000_0120, 32'h1111_2222);
    put(32'h0000_0124, 32'h3333_4444);
    put(32'h0000_0130, 32'h0000_5555);
    put(32'h0000_0230, 32'hFFFF_FFFF);
    activate(2);
    slow = 1'b0;
    check("blk0", peek(32'h0000_0220), 32'h1111_2222);
    check("blk1", peek(32'h0000_0224), 32'h3333_4444);
    check("blk sar", peek(32'h0000_0084), 32'h0000_0128);
    check("blk dar", peek(32'h0000_0088), 32'h0000_0220);
    check("blk cnt", peek(32'h0000_008C), 32'h0202_0000);
    check("chain cnt", peek(32'h0000_009C), 32'h0000_0000);
    check("chain dst", peek(32'h0000_0230), 32'hFFFF_5555);
    check("chain dar", peek(32'h0000_0098), 32'h0000_022E);
    check("irq every", 32'(irq_seen), 32'h0000_0004);
    check("sizes", 32'(mem.wsz_seen), 32'h0000_0007);
  endtask
  initial begin
    rst = 1'b1;
    req = 8'h00;
    en = 8'hFF;
    skip = 1'b0;
    slow = 1'b0;
    acc_seen = 8'h00;
    irq_seen = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_normal();
    t_repeat();
    t_block_chain();
    summarize();
  end
endmodule // event_transfer_engine_tb_top
